/* logic/lpc_pkg.sv */
// Package: constants and types for the level-2 partition and cacheability logic
package lpc_pkg;
  // Cache size modes (same encoding on both variants)
  typedef enum logic [2:0] {
    LPC_MODE_0 = 3'h0,
    LPC_MODE_1 = 3'h1,
    LPC_MODE_2 = 3'h2,
    LPC_MODE_3 = 3'h3,
    LPC_MODE_4 = 3'h4
  } lpc_mode_t;

  // Access routing decisions
  typedef enum logic [1:0] {
    LPC_ROUTE_SRAM    = 2'h0,
    LPC_ROUTE_L2      = 2'h1,
    LPC_ROUTE_L1_ONLY = 2'h2,
    LPC_ROUTE_DIRECT  = 2'h3
  } lpc_route_t;

  localparam int        LPC_ADDR_W        = 32;
  localparam int        LPC_REGION_SHIFT  = 24;        // 16 Mbyte regions
  localparam int        LPC_NUM_REGIONS   = 256;
  localparam int        LPC_IDX_W         = 8;
  localparam int        LPC_KB_W          = 11;        // Kbyte counts up to 1024
  localparam logic [2:0] LPC_MODE_RST     = 3'h0;      // All SRAM after reset
  localparam logic      LPC_CACHE_BIT_RST = 1'b0;      // Nothing cached after reset
  // First external region base and the bit it lands on per variant
  localparam logic [7:0] LPC_EXT_BASE_REGION  = 8'h80;
  localparam logic [7:0] LPC_SMALL_FIRST_IDX  = 8'h00;
  localparam logic [7:0] LPC_LARGE_FIRST_IDX  = 8'h80;
  // Small variant (64 Kbyte): cache Kbytes and ways per mode
  localparam logic [10:0] LPC_SMALL_TOTAL_KB  = 11'h040;
  localparam logic [10:0] LPC_SMALL_CACHE_KB [5] = '{11'h000, 11'h010, 11'h020, 11'h030, 11'h040};
  localparam logic [2:0]  LPC_SMALL_WAYS     [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
  // Large variant (1024 Kbyte): always four ways when enabled
  localparam logic [10:0] LPC_LARGE_TOTAL_KB  = 11'h400;
  localparam logic [10:0] LPC_LARGE_CACHE_KB [5] = '{11'h000, 11'h020, 11'h040, 11'h080, 11'h100};
  localparam logic [2:0]  LPC_LARGE_WAYS     [5] = '{3'h0, 3'h4, 3'h4, 3'h4, 3'h4};
endpackage : lpc_pkg

/* logic/lpc_partition.sv */
// Level-2 partition and external-region cacheability configuration and decode
// Function
// - Reset: cache off, all memory is SRAM
// - One cacheable bit per 16 Mbyte region
// - Reset clears every region cacheable bit
// - Cacheable region goes to L2, else L1
// - Noncacheable access passes directly, no allocation
// - L2 cache never holds on-chip SRAM addresses
// - Cache taken from top, SRAM from zero
// - Small variant ways: 1, 2, 3, 4
// - Small variant max mode: no SRAM
// - Large variant: 0/32/64/128/256 Kbyte cache sizes
// - Large variant cache is four ways
// - 80000000h region maps to bit 0/128
module lpc_partition
  import lpc_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b0                   // 0: 64 Kbyte, 1: 1024 Kbyte
) (
  input  wire logic                         clk_in,          // 25 MHz clock
  input  wire logic                         sys_rst_in,      // Async reset, active high
  input  wire logic                         mode_wr_in,      // Write cache size mode
  input  wire logic [2:0]                   mode_data_in,    // Mode value 0..4
  input  wire logic                         bit_wr_in,       // Write one cacheable bit
  input  wire logic [lpc_pkg::LPC_IDX_W-1:0] bit_idx_in,     // Bit index
  input  wire logic                         bit_data_in,     // Bit value
  input  wire logic [lpc_pkg::LPC_IDX_W-1:0] rd_idx_in,      // Bit index to read back
  input  wire logic                         acc_valid_in,    // Core access request
  input  wire logic [lpc_pkg::LPC_ADDR_W-1:0] acc_addr_in,   // Core access address
  output logic      [2:0]                   mode_out,        // Current mode readback
  output logic                              rd_bit_out,      // Read-back cacheable bit
  output logic      [lpc_pkg::LPC_KB_W-1:0] sram_kb_out,     // Addressable SRAM Kbytes
  output logic      [lpc_pkg::LPC_KB_W-1:0] cache_kb_out,    // Cache Kbytes
  output logic      [2:0]                   ways_out,        // Cache ways, 0 when off
  output logic                              cache_en_out,    // L2 cache enabled
  output logic                              route_valid_out, // Route result valid
  output logic      [1:0]                   route_out        // lpc_route_t decision
);
  import lpc_pkg::*;

  localparam logic [LPC_KB_W-1:0] TOTAL_KB = LARGE_VARIANT ? LPC_LARGE_TOTAL_KB : LPC_SMALL_TOTAL_KB;
  localparam logic [LPC_IDX_W-1:0] FIRST_IDX = LARGE_VARIANT ? LPC_LARGE_FIRST_IDX : LPC_SMALL_FIRST_IDX;

  // Cache Kbytes for a mode
  function automatic logic [LPC_KB_W-1:0] cache_kb_f(input logic [2:0] m);
    cache_kb_f = LARGE_VARIANT ? LPC_LARGE_CACHE_KB[m] : LPC_SMALL_CACHE_KB[m];
  endfunction

  // Way count for a mode
  function automatic logic [2:0] ways_f(input logic [2:0] m);
    ways_f = LARGE_VARIANT ? LPC_LARGE_WAYS[m] : LPC_SMALL_WAYS[m];
  endfunction

  // Region bit index for an external address
  function automatic logic [LPC_IDX_W-1:0] region_idx_f(input logic [LPC_ADDR_W-1:0] a);
    logic [LPC_IDX_W-1:0] reg_no;
    reg_no = a[LPC_ADDR_W-1:LPC_REGION_SHIFT];
    region_idx_f = reg_no - LPC_EXT_BASE_REGION + FIRST_IDX;
  endfunction

  logic [2:0]                 mode_reg,  mode_next;
  logic [LPC_NUM_REGIONS-1:0] bits_reg,  bits_next;
  logic [LPC_KB_W-1:0]        sram_kb_reg, sram_kb_next;
  logic [LPC_KB_W-1:0]        cache_kb_reg, cache_kb_next;
  logic [2:0]                 ways_reg,  ways_next;
  logic                       rd_bit_reg, rd_bit_next;
  logic                       rvalid_reg, rvalid_next;
  logic [1:0]                 route_reg, route_next;
  logic                       cache_en_reg, cache_en_next;

  // Configuration next state
  always_comb begin
    mode_next = mode_reg;
    bits_next = bits_reg;
    if (mode_wr_in && mode_data_in <= 3'(LPC_MODE_4)) begin
      mode_next = mode_data_in;
    end
    if (bit_wr_in) begin
      bits_next[bit_idx_in] = bit_data_in;
    end
  end

  // Configuration registers
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mode_reg <= LPC_MODE_RST;
      bits_reg <= {LPC_NUM_REGIONS{LPC_CACHE_BIT_RST}};
    end else begin
      mode_reg <= mode_next;
      bits_reg <= bits_next;
    end
  end

  // Partition derived from the current mode
  always_comb begin
    cache_kb_next = cache_kb_f(mode_reg);
    sram_kb_next  = TOTAL_KB - cache_kb_f(mode_reg);
    ways_next     = ways_f(mode_reg);
    cache_en_next = (cache_kb_f(mode_reg) != '0);
    rd_bit_next   = bits_reg[rd_idx_in];
  end

  // Access route decode
  always_comb begin
    rvalid_next = acc_valid_in;
    route_next  = LPC_ROUTE_DIRECT;
    if (acc_addr_in[LPC_ADDR_W-1:LPC_REGION_SHIFT] < LPC_EXT_BASE_REGION) begin
      route_next = LPC_ROUTE_SRAM;
    end else if (bits_reg[region_idx_f(acc_addr_in)]) begin
      route_next = (cache_kb_reg != '0) ? LPC_ROUTE_L2 : LPC_ROUTE_L1_ONLY;
    end else begin
      route_next = LPC_ROUTE_DIRECT;
    end
  end

  // Output registers
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sram_kb_reg  <= TOTAL_KB;
      cache_kb_reg <= '0;
      ways_reg     <= 3'h0;
      cache_en_reg <= 1'b0;
      rd_bit_reg   <= 1'b0;
      rvalid_reg   <= 1'b0;
      route_reg    <= LPC_ROUTE_DIRECT;
    end else begin
      sram_kb_reg  <= sram_kb_next;
      cache_kb_reg <= cache_kb_next;
      ways_reg     <= ways_next;
      cache_en_reg <= cache_en_next;
      rd_bit_reg   <= rd_bit_next;
      rvalid_reg   <= rvalid_next;
      route_reg    <= route_next;
    end
  end

  assign mode_out        = mode_reg;
  assign rd_bit_out      = rd_bit_reg;
  assign sram_kb_out     = sram_kb_reg;
  assign cache_kb_out    = cache_kb_reg;
  assign ways_out        = ways_reg;
  assign cache_en_out    = cache_en_reg;
  assign route_valid_out = rvalid_reg;
  assign route_out       = route_reg;

  // Assertions
  property p_reset_sram;
    @(posedge clk_in) $fell(sys_rst_in) |-> (sram_kb_out == TOTAL_KB) && !cache_en_out;
  endproperty
  a_reset_sram: assert property (p_reset_sram) else $error("SRAM not full after reset");

  property p_bit_write;
    @(posedge clk_in) disable iff (sys_rst_in)
      bit_wr_in && !(rd_idx_in != bit_idx_in) ##1 (rd_idx_in == $past(bit_idx_in))
      |=> rd_bit_out == $past(bit_data_in, 2);
  endproperty
  a_bit_write: assert property (p_bit_write) else $error("Region bit readback wrong");

  property p_reset_clear;
    @(posedge clk_in) $fell(sys_rst_in) |-> (route_valid_out == 1'b0) && (bits_reg == '0);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("Region bits not cleared");

  property p_direct;
    @(posedge clk_in) disable iff (sys_rst_in)
      acc_valid_in && acc_addr_in[31:24] >= 8'h80 && !bits_reg[region_idx_f(acc_addr_in)]
      |=> route_out == LPC_ROUTE_DIRECT;
  endproperty
  a_direct: assert property (p_direct) else $error("Noncacheable not direct");

  property p_onchip;
    @(posedge clk_in) disable iff (sys_rst_in)
      acc_valid_in && acc_addr_in[31:24] < 8'h80 |=> route_out == LPC_ROUTE_SRAM;
  endproperty
  a_onchip: assert property (p_onchip) else $error("On-chip routed to cache");

  property p_split;
    @(posedge clk_in) disable iff (sys_rst_in) sram_kb_out + cache_kb_out == TOTAL_KB;
  endproperty
  a_split: assert property (p_split) else $error("Partition does not sum");

  property p_ways;
    @(posedge clk_in) disable iff (sys_rst_in)
      mode_wr_in && mode_data_in == 3'h2 |=> ##1 ways_out == (LARGE_VARIANT ? 3'h4 : 3'h2);
  endproperty
  a_ways: assert property (p_ways) else $error("Way count wrong");

  property p_apply;
    @(posedge clk_in) disable iff (sys_rst_in)
      mode_wr_in && mode_data_in <= 3'h4 |=> mode_out == $past(mode_data_in);
  endproperty
  a_apply: assert property (p_apply) else $error("Mode write not applied");

  // Out-of-range mode writes leave the mode alone
  property p_refuse;
    @(posedge clk_in) disable iff (sys_rst_in)
      mode_wr_in && mode_data_in > 3'h4 |=> $stable(mode_out);
  endproperty
  a_refuse: assert property (p_refuse) else $error("Illegal mode accepted");

  // Cacheable external access goes to a cache level
  property p_cacheable;
    @(posedge clk_in) disable iff (sys_rst_in)
      acc_valid_in && acc_addr_in[31:24] >= 8'h80 && bits_reg[region_idx_f(acc_addr_in)]
      |=> route_out == ($past(cache_en_out) ? LPC_ROUTE_L2 : LPC_ROUTE_L1_ONLY);
  endproperty
  a_cacheable: assert property (p_cacheable) else $error("Cacheable access misrouted");

  // First external region uses the variant's first bit
  property p_first_idx;
    @(posedge clk_in) disable iff (sys_rst_in)
      acc_valid_in && acc_addr_in[31:24] == 8'h80 && bits_reg[FIRST_IDX]
      |=> route_out != LPC_ROUTE_DIRECT;
  endproperty
  a_first_idx: assert property (p_first_idx) else $error("First region bit not used");

  // Maximum small-variant mode leaves no SRAM
  property p_no_sram;
    @(posedge clk_in) disable iff (sys_rst_in)
      (LARGE_VARIANT == 1'b0) && mode_out == 3'h4 |=> sram_kb_out == 11'h000;
  endproperty
  a_no_sram: assert property (p_no_sram) else $error("SRAM left in max mode");

  // Small variant way count follows the size
  property p_small_ways;
    @(posedge clk_in) disable iff (sys_rst_in)
      (LARGE_VARIANT == 1'b0) && mode_out >= 3'h2 |=> ways_out == $past(mode_out);
  endproperty
  a_small_ways: assert property (p_small_ways) else $error("Small way count wrong");

  // Large variant is always four ways when on
  property p_large_ways;
    @(posedge clk_in) disable iff (sys_rst_in)
      (LARGE_VARIANT == 1'b1) && mode_out != 3'h0 |=> ways_out == 3'h4;
  endproperty
  a_large_ways: assert property (p_large_ways) else $error("Large way count wrong");

  // Smallest small-variant cache is 16 Kbytes
  property p_small_16;
    @(posedge clk_in) disable iff (sys_rst_in)
      (LARGE_VARIANT == 1'b0) && mode_out == 3'h1 |=> cache_kb_out == 11'h010;
  endproperty
  a_small_16: assert property (p_small_16) else $error("Small 16K size wrong");

  // Smallest large-variant cache is 32 Kbytes
  property p_large_32;
    @(posedge clk_in) disable iff (sys_rst_in)
      (LARGE_VARIANT == 1'b1) && mode_out == 3'h1 |=> cache_kb_out == 11'h020;
  endproperty
  a_large_32: assert property (p_large_32) else $error("Large 32K size wrong");

  // Large 128 Kbyte cache leaves 896 Kbytes of SRAM
  property p_large_sram;
    @(posedge clk_in) disable iff (sys_rst_in)
      (LARGE_VARIANT == 1'b1) && mode_out == 3'h3 |=> sram_kb_out == 11'h380;
  endproperty
  a_large_sram: assert property (p_large_sram) else $error("Large SRAM size wrong");

  // Way count is zero right after reset
  property p_reset_ways;
    @(posedge clk_in) $fell(sys_rst_in) |-> (ways_out == 3'h0) && (mode_out == 3'h0);
  endproperty
  a_reset_ways: assert property (p_reset_ways) else $error("Ways not zero after reset");

  // Enable flag tracks a nonzero cache size
  property p_enable;
    @(posedge clk_in) disable iff (sys_rst_in)
      cache_en_out == (cache_kb_out != 11'h000);
  endproperty
  a_enable: assert property (p_enable) else $error("Enable flag disagrees with size");
endmodule // lpc_partition

/* verif/lpc_core_model.sv */
// Processor core model that presents accesses to the partition block
module lpc_core_model (
  input  wire logic        clk_in,        // Bench clock
  input  wire logic        req_in,        // Issue one access
  input  wire logic [31:0] addr_in,       // Address to issue
  output logic             acc_valid_out, // Access strobe
  output logic      [31:0] acc_addr_out   // Access address
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet outputs at time zero
  initial begin
    acc_valid_out = 1'b0;
    acc_addr_out  = 32'h0;
  end
  // Drive on the falling edge; idle address toggles so a stale value is never trusted
  always @(negedge clk_in) begin
    acc_valid_out <= req_in;
    acc_addr_out  <= req_in ? addr_in : ~acc_addr_out;
  end
endmodule // lpc_core_model

/* verif/lpc_partition_tb_top.sv */
// Self-checking bench for both memory-size variants of the partition block
module lpc_partition_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lpc_pkg::*;
  logic        clk_in, sys_rst_in, mode_wr, bit_wr, bit_data, req, acc_valid;
  logic [2:0]  mode_data;
  logic [7:0]  bit_idx, rd_idx;
  logic [31:0] req_addr, acc_addr, seed, r;
  logic [2:0]  mode_o [2];
  logic [2:0]  ways_o [2];
  logic [10:0] sram_o [2];
  logic [10:0] cache_o [2];
  logic        rd_o [2];
  logic        en_o [2];
  logic        rv_o [2];
  logic [1:0]  route_o [2];
  bit          bits [256];
  int          n_mismatch, checks, mode;

  lpc_core_model u_core (.clk_in(clk_in), .req_in(req), .addr_in(req_addr),
    .acc_valid_out(acc_valid), .acc_addr_out(acc_addr));
  // Index 0 is the 64 Kbyte variant, index 1 the 1024 Kbyte variant
  for (genvar g = 0; g < 2; g++) begin : g_v
    lpc_partition #(.LARGE_VARIANT(g == 1)) u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .mode_wr_in(mode_wr), .mode_data_in(mode_data), .bit_wr_in(bit_wr), .bit_idx_in(bit_idx),
      .bit_data_in(bit_data), .rd_idx_in(rd_idx), .acc_valid_in(acc_valid), .acc_addr_in(acc_addr),
      .mode_out(mode_o[g]), .rd_bit_out(rd_o[g]), .sram_kb_out(sram_o[g]), .cache_kb_out(cache_o[g]),
      .ways_out(ways_o[g]), .cache_en_out(en_o[g]), .route_valid_out(rv_o[g]), .route_out(route_o[g]));
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected route from the bench's own copy of the region bits
  function automatic logic [1:0] exp_route(logic [31:0] a, int v);
    logic [7:0] idx;
    idx = a[31:24] - 8'h80 + (v ? 8'h80 : 8'h00);
    if (a[31:24] < 8'h80) return 2'h0;
    if (!bits[idx]) return 2'h3;
    return (mode != 0) ? 2'h1 : 2'h2;
  endfunction
  function automatic logic [10:0] exp_cache(int v);
    if (v == 0) return 11'(mode * 16);
    return (mode == 0) ? 11'h000 : 11'(32 << (mode - 1));
  endfunction

  task automatic chk_val(input logic [10:0] got, input logic [10:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check_sizes();
    for (int v = 0; v < 2; v++) begin
      chk_val(mode_o[v], 11'(mode));
      chk_val(cache_o[v], exp_cache(v));
      chk_val(sram_o[v], (v ? 11'h400 : 11'h040) - exp_cache(v));
      chk_val(ways_o[v], v ? ((mode != 0) ? 11'h4 : 11'h0) : 11'(mode));
      chk_val(en_o[v], 11'(mode != 0));
    end
  endtask
  task automatic wr_mode(input logic [2:0] m);
    @(negedge clk_in);
    mode_wr   = 1'b1;
    mode_data = m;
    @(negedge clk_in);
    mode_wr = 1'b0;
    if (m <= 3'h4) mode = m;
    repeat (2) @(negedge clk_in);
    check_sizes();
  endtask
  task automatic wr_bit(input logic [7:0] idx, input logic d);
    @(negedge clk_in);
    bit_wr   = 1'b1;
    bit_idx  = idx;
    bit_data = d;
    rd_idx   = idx;
    @(negedge clk_in);
    bit_wr      = 1'b0;
    bits[idx]   = d;
    @(negedge clk_in);
    for (int v = 0; v < 2; v++) chk_val(rd_o[v], 11'(d));
  endtask
  task automatic access(input logic [31:0] a);
    @(posedge clk_in);
    req      = 1'b1;
    req_addr = a;
    @(posedge clk_in);
    req = 1'b0;
    @(negedge clk_in);
    for (int v = 0; v < 2; v++) begin
      chk_val(rv_o[v], 11'h1);
      chk_val(route_o[v], exp_route(a, v));
    end
  endtask

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  initial begin
    #400000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    {sys_rst_in, mode_wr, bit_wr, bit_data, req, mode_data, bit_idx, rd_idx} = 24'h800000;
    req_addr = 32'h0;
    seed     = 32'hC4C63FE0;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    sys_rst_in = 1'b0;
    check_sizes();
    for (int v = 0; v < 2; v++) chk_val(rv_o[v], 11'h0);
    rd_idx = 8'h80;
    @(negedge clk_in);
    for (int v = 0; v < 2; v++) chk_val(rd_o[v], 11'h0);
    access(32'h8000_0000);
    wr_bit(8'h00, 1'b1);
    access(32'h8000_0000);
    for (int m = 0; m < 6; m++) begin
      wr_mode(3'(m));
      access(32'h80FF_FFFF);
    end
    repeat (300) begin
      r = rnd();
      if (r[1:0] == 2'h0) wr_bit({r[8], 4'h0, r[4:2]}, r[9]);
      else if (r[1:0] == 2'h1 && r[7:5] == 3'h0) wr_mode(r[12:10]);
      else if (r[13]) access({5'h10, r[16:14], r[31:8]});
      else if (mode == 0) access({16'h0000, r[31:16]});
      else access(rnd() | 32'h8000_0000);
    end
    wr_mode(3'h0);
    access(32'h0000_1000);
    give_verdict();
  end
endmodule // lpc_partition_tb_top
